// file: isfc_front_cfg.sv
// receiver front-end config and status registers on an axi4-lite slave
// What this block does
// R1: gain readback read-only, writes change nothing
// R2: gain codes update periodically on their own
// R3: coarse gain code read in bits 13:8
// R4: fine gain code read in bits 5:0
// R5: gain equals ten times 1.189 to code
// R6: bit 15 blocks extrapolation on gain changes
// R7: bit 13 runs open-coil check, self-clears
// R8: bit 11 clears turn counter, self-clears
// R9: status bit 13 set means open coil
// R10: four rectifiers, two 2-bit selectors each
// R11: equal selectors tie negative input to dc
// R12: codes pick pins 0-3 or 4-7
// R13: routing resets f249, others zero
// R14: reserved bits read zero, writes ignored
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "isfc_map.svh"
module isfc_front_cfg
  import isfc_pkg::*;
#(
  parameter int GAIN_PERIOD_CYC = `ISFC_GAIN_PERIOD_NS / `ISFC_CLK_NS,
  parameter int PEAK_W          = 12,
  parameter int N_PINS          = 8
) (
  input  wire logic              CLK_SYS_I,
  input  wire logic              RESET_I,
  input  wire logic              S_AXI_AWVALID_I,
  output logic                   S_AXI_AWREADY_O,
  input  wire logic [7:0]        S_AXI_AWADDR_I,
  input  wire logic              S_AXI_WVALID_I,
  output logic                   S_AXI_WREADY_O,
  input  wire logic [31:0]       S_AXI_WDATA_I,
  input  wire logic [3:0]        S_AXI_WSTRB_I,
  output logic                   S_AXI_BVALID_O,
  input  wire logic              S_AXI_BREADY_I,
  output logic [1:0]             S_AXI_BRESP_O,
  input  wire logic              S_AXI_ARVALID_I,
  output logic                   S_AXI_ARREADY_O,
  input  wire logic [7:0]        S_AXI_ARADDR_I,
  output logic                   S_AXI_RVALID_O,
  input  wire logic              S_AXI_RREADY_I,
  output logic [31:0]            S_AXI_RDATA_O,
  output logic [1:0]             S_AXI_RRESP_O,
  input  wire logic [PEAK_W-1:0] COARSE_PEAK_I,
  input  wire logic [PEAK_W-1:0] FINE_PEAK_I,
  input  wire logic              OSC_GAIN_CHG_I,
  input  wire logic              OFFSET_CHG_I,
  input  wire logic [N_PINS-1:0] COIL_OPEN_I,
  output logic [5:0]             COARSE_GAIN_O,
  output logic [5:0]             FINE_GAIN_O,
  output logic                   EXTRAP_ALLOW_O,
  output logic                   COIL_TEST_EN_O,
  output logic                   TURN_CNT_CLR_O,
  output isfc_route_t [3:0]      COARSE_ROUTE_O,
  output logic                   IRQ_O
);

  localparam int SETTLE_CYC =
    (`ISFC_OC_SETTLE_NS + `ISFC_CLK_NS - 1) / `ISFC_CLK_NS;
  localparam int SCNT_W = $clog2(SETTLE_CYC + 1);
  localparam int GCNT_W = $clog2(GAIN_PERIOD_CYC + 1);

  // axi write and read channel state
  logic        awready_r;
  logic        aw_got_r;
  logic [7:0]  awaddr_r;
  logic        wready_r;
  logic        w_got_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  // register state
  logic        extrp_off_r;
  logic        chk_go_r;
  logic        turn_clr_r;
  logic        open_found_r;
  logic [15:0] route_r;
  logic        chan_sel_r;
  logic [3:0]  irq_st_r;
  logic [3:0]  irq_msk_r;
  logic        irq_r;
  logic        allow_r;
  logic        test_en_r;
  isfc_route_t [3:0] route_out_r;

  // open-coil check and gain timer state
  isfc_oc_state_t    oc_state_r;
  isfc_oc_state_t    oc_state_nxt;
  logic [SCNT_W-1:0] settle_cnt_r;
  logic [GCNT_W-1:0] gain_cnt_r;
  logic [N_PINS-1:0] open_meta_r;
  logic [N_PINS-1:0] open_sync_r;

  wire        aw_hs;
  wire        w_hs;
  wire        b_hs;
  wire        ar_hs;
  wire        r_hs;
  wire        do_wr;
  wire [5:0]  wr_idx;
  wire [5:0]  rd_idx;
  wire [15:0] wmask;
  wire [15:0] wval;
  wire        wr_ctrl;
  wire        wr_route;
  wire        wr_irq_st;
  wire        wr_irq_msk;
  wire        wr_chan;
  wire        wr_gain;
  wire        wr_hit;
  wire        rd_hit;
  wire [15:0] rd_val;
  wire [15:0] ctrl_rb;
  wire [15:0] stat_rb;
  wire        gain_tick;
  wire        coarse_chg;
  wire        fine_chg;
  wire        settle_end;
  wire        chk_start;
  wire [3:0]  irq_ev;
  wire [3:0]  irq_clr;
  wire [3:0]  irq_st_nxt;
  wire [5:0]  coarse_code;
  wire [5:0]  fine_code;
  isfc_gain_rb_t gain_rb;
  isfc_route_t [3:0] route_nxt;

  // handshakes and write decode
  assign aw_hs  = S_AXI_AWVALID_I & awready_r;
  assign w_hs   = S_AXI_WVALID_I & wready_r;
  assign b_hs   = bvalid_r & S_AXI_BREADY_I;
  assign ar_hs  = S_AXI_ARVALID_I & arready_r;
  assign r_hs   = rvalid_r & S_AXI_RREADY_I;
  assign do_wr  = aw_got_r & w_got_r & ~bvalid_r;
  assign wr_idx = awaddr_r[7:2];
  assign rd_idx = S_AXI_ARADDR_I[7:2];
  assign wmask  = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign wval   = wdata_r[15:0] & wmask;

  assign wr_gain    = do_wr && (wr_idx == `ISFC_IDX_GAIN);
  assign wr_ctrl    = do_wr && (wr_idx == `ISFC_IDX_CTRL);
  assign wr_route   = do_wr && (wr_idx == `ISFC_IDX_ROUTE);
  assign wr_irq_st  = do_wr && (wr_idx == `ISFC_IDX_IRQ_ST);
  assign wr_irq_msk = do_wr && (wr_idx == `ISFC_IDX_IRQ_MSK);
  assign wr_chan    = do_wr && (wr_idx == `ISFC_IDX_CHAN);
  assign wr_hit = wr_gain | wr_ctrl | wr_route | wr_irq_st | wr_irq_msk |
                  wr_chan | (do_wr && (wr_idx == `ISFC_IDX_STAT));

  // readback words, reserved bits zero
  assign gain_rb.rsv_hi = 2'h0; // R14
  assign gain_rb.coarse = coarse_code; // R3
  assign gain_rb.rsv_lo = 2'h0;
  assign gain_rb.fine   = fine_code; // R4
  assign ctrl_rb = (16'(extrp_off_r) << `ISFC_CTRL_EXTRP_BIT) |
                   (16'(chk_go_r) << `ISFC_CTRL_CHK_BIT) |
                   (16'(turn_clr_r) << `ISFC_CTRL_TURN_BIT); // R14
  assign stat_rb = 16'(open_found_r) << `ISFC_STAT_OPEN_BIT; // R9

  assign rd_hit = (rd_idx == `ISFC_IDX_GAIN) | (rd_idx == `ISFC_IDX_CTRL) |
                  (rd_idx == `ISFC_IDX_STAT) | (rd_idx == `ISFC_IDX_ROUTE) |
                  (rd_idx == `ISFC_IDX_IRQ_ST) |
                  (rd_idx == `ISFC_IDX_IRQ_MSK) |
                  (rd_idx == `ISFC_IDX_CHAN);
  assign rd_val =
    (rd_idx == `ISFC_IDX_GAIN)    ? gain_rb :
    (rd_idx == `ISFC_IDX_CTRL)    ? ctrl_rb :
    (rd_idx == `ISFC_IDX_STAT)    ? stat_rb :
    (rd_idx == `ISFC_IDX_ROUTE)   ? route_r :
    (rd_idx == `ISFC_IDX_IRQ_ST)  ? {12'h000, irq_st_r} :
    (rd_idx == `ISFC_IDX_IRQ_MSK) ? {12'h000, irq_msk_r} :
    (rd_idx == `ISFC_IDX_CHAN)    ? {15'h0000, chan_sel_r} : 16'h0000;

  // axi write path
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      awready_r <= 1'b1;
      aw_got_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wready_r  <= 1'b1;
      w_got_r   <= 1'b0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `ISFC_RESP_OKAY;
    end else begin
      if (aw_hs) begin
        awaddr_r <= S_AXI_AWADDR_I;
      end
      if (w_hs) begin
        wdata_r <= S_AXI_WDATA_I;
        wstrb_r <= S_AXI_WSTRB_I;
      end
      awready_r <= aw_hs ? 1'b0 : (b_hs ? 1'b1 : awready_r);
      wready_r  <= w_hs ? 1'b0 : (b_hs ? 1'b1 : wready_r);
      aw_got_r  <= aw_hs ? 1'b1 : (do_wr ? 1'b0 : aw_got_r);
      w_got_r   <= w_hs ? 1'b1 : (do_wr ? 1'b0 : w_got_r);
      bvalid_r  <= do_wr ? 1'b1 : (b_hs ? 1'b0 : bvalid_r);
      if (do_wr) begin
        bresp_r <= wr_hit ? `ISFC_RESP_OKAY : `ISFC_RESP_SLVERR; // R1
      end
    end
  end

  // axi read path
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `ISFC_RESP_OKAY;
    end else begin
      arready_r <= ar_hs ? 1'b0 : (r_hs ? 1'b1 : arready_r);
      rvalid_r  <= ar_hs ? 1'b1 : (r_hs ? 1'b0 : rvalid_r);
      if (ar_hs) begin
        rdata_r <= {16'h0000, rd_val};
        rresp_r <= rd_hit ? `ISFC_RESP_OKAY : `ISFC_RESP_SLVERR;
      end
    end
  end

  // periodic gain update tick
  assign gain_tick = (gain_cnt_r == GCNT_W'(GAIN_PERIOD_CYC - 1));

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      gain_cnt_r <= '0;
    end else begin
      gain_cnt_r <= gain_tick ? '0 : gain_cnt_r + GCNT_W'(1); // R2
    end
  end

  // codes drive the amplifier: gain = base * ratio ** code
  isfc_gain_track #(
    .PEAK_W (PEAK_W),
    .CODE_W (6)
  ) u_coarse_gain (
    .clk_i     (CLK_SYS_I),
    .reset_i   (RESET_I),
    .tick_i    (gain_tick),
    .peak_i    (COARSE_PEAK_I),
    .code_o    (coarse_code),
    .changed_o (coarse_chg)
  ); // R5

  isfc_gain_track #(
    .PEAK_W (PEAK_W),
    .CODE_W (6)
  ) u_fine_gain (
    .clk_i     (CLK_SYS_I),
    .reset_i   (RESET_I),
    .tick_i    (gain_tick),
    .peak_i    (FINE_PEAK_I),
    .code_o    (fine_code),
    .changed_o (fine_chg)
  ); // R5

  assign COARSE_GAIN_O = coarse_code;
  assign FINE_GAIN_O   = fine_code;

  // open-coil detector sequence
  assign chk_start  = wr_ctrl && wstrb_r[1] &&
                      wdata_r[`ISFC_CTRL_CHK_BIT];
  assign settle_end = (settle_cnt_r == SCNT_W'(SETTLE_CYC - 1));

  always_comb begin
    oc_state_nxt = oc_state_r;
    case (oc_state_r)
      OC_IDLE: begin
        if (chk_go_r) begin
          oc_state_nxt = OC_SETTLE;
        end
      end
      OC_SETTLE: begin
        if (settle_end) begin
          oc_state_nxt = OC_SAMPLE;
        end
      end
      OC_SAMPLE: oc_state_nxt = OC_DONE;
      OC_DONE:   oc_state_nxt = OC_IDLE;
      default:   oc_state_nxt = OC_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      open_meta_r <= '0;
      open_sync_r <= '0;
    end else begin
      open_meta_r <= COIL_OPEN_I;
      open_sync_r <= open_meta_r;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      oc_state_r   <= OC_IDLE;
      settle_cnt_r <= '0;
      chk_go_r     <= 1'b0;
      open_found_r <= 1'b0;
      test_en_r    <= 1'b0;
    end else begin
      oc_state_r   <= oc_state_nxt;
      settle_cnt_r <= (oc_state_r == OC_SETTLE) ?
                      settle_cnt_r + SCNT_W'(1) : '0;
      test_en_r    <= (oc_state_nxt == OC_SETTLE) ||
                      (oc_state_nxt == OC_SAMPLE);
      if (oc_state_r == OC_SAMPLE) begin
        open_found_r <= |open_sync_r; // R9
      end
      if (oc_state_r == OC_DONE) begin
        chk_go_r <= 1'b0; // R7
      end else if (chk_start && (oc_state_r == OC_IDLE)) begin
        chk_go_r <= 1'b1; // R7
      end
    end
  end

  // control, routing and interrupt registers
  assign irq_ev[`ISFC_IRQ_CHK_DONE] = (oc_state_r == OC_DONE);
  assign irq_ev[`ISFC_IRQ_OPEN]     = (oc_state_r == OC_SAMPLE) &
                                      (|open_sync_r);
  assign irq_ev[`ISFC_IRQ_TURN]     = turn_clr_r;
  assign irq_ev[`ISFC_IRQ_GAIN]     = coarse_chg | fine_chg;
  assign irq_clr    = wr_irq_st ? (wval[3:0]) : 4'h0;
  assign irq_st_nxt = (irq_st_r & ~irq_clr) | irq_ev;

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      extrp_off_r <= 1'(`ISFC_RST_CTRL >> `ISFC_CTRL_EXTRP_BIT);
      turn_clr_r  <= 1'b0;
      route_r     <= `ISFC_RST_ROUTE; // R13
      chan_sel_r  <= 1'b0;
      irq_st_r    <= `ISFC_RST_IRQ;
      irq_msk_r   <= `ISFC_RST_IRQ;
      irq_r       <= 1'b0;
      allow_r     <= 1'b1;
    end else begin
      if (wr_ctrl && wstrb_r[1]) begin
        extrp_off_r <= wdata_r[`ISFC_CTRL_EXTRP_BIT];
      end
      turn_clr_r <= wr_ctrl && wstrb_r[1] &&
                    wdata_r[`ISFC_CTRL_TURN_BIT]; // R8
      if (wr_route) begin
        route_r <= (route_r & ~wmask) | wval; // R10
      end
      if (wr_chan && wstrb_r[0]) begin
        chan_sel_r <= wdata_r[`ISFC_CHAN_SEL_BIT];
      end
      if (wr_irq_msk) begin
        irq_msk_r <= (irq_msk_r & ~wmask[3:0]) | wval[3:0];
      end
      irq_st_r <= irq_st_nxt;
      irq_r    <= |(irq_st_r & irq_msk_r);
      allow_r  <= ~(extrp_off_r & (coarse_chg | fine_chg |
                   OSC_GAIN_CHG_I | OFFSET_CHG_I)); // R6
    end
  end

  // rectifier input routing decode
  for (genvar i = 0; i < 4; i++) begin : g_route
    assign route_nxt[i].pos_pin = {chan_sel_r, route_r[4*i+3 -: 2]}; // R12
    assign route_nxt[i].neg_pin = {chan_sel_r, route_r[4*i+1 -: 2]}; // R12
    assign route_nxt[i].neg_dc  =
      (route_r[4*i+1 -: 2] == route_r[4*i+3 -: 2]); // R11
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      route_out_r <= '0;
    end else begin
      route_out_r <= route_nxt;
    end
  end

  assign S_AXI_AWREADY_O = awready_r;
  assign S_AXI_WREADY_O  = wready_r;
  assign S_AXI_BVALID_O  = bvalid_r;
  assign S_AXI_BRESP_O   = bresp_r;
  assign S_AXI_ARREADY_O = arready_r;
  assign S_AXI_RVALID_O  = rvalid_r;
  assign S_AXI_RDATA_O   = rdata_r;
  assign S_AXI_RRESP_O   = rresp_r;
  assign EXTRAP_ALLOW_O  = allow_r;
  assign COIL_TEST_EN_O  = test_en_r;
  assign TURN_CNT_CLR_O  = turn_clr_r;
  assign COARSE_ROUTE_O  = route_out_r;
  assign IRQ_O           = irq_r;

  // checks
  property p_gain_ro;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    wr_gain && !gain_tick |=> $stable(coarse_code) && $stable(fine_code);
  endproperty
  a_gain_ro: assert property (p_gain_ro) else $error("gain written"); // R1

  property p_gain_dn;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    gain_tick && (FINE_PEAK_I > `ISFC_PEAK_HI) && (fine_code != 6'h00)
    |=> fine_code == $past(fine_code) - 6'h01;
  endproperty
  a_gain_dn: assert property (p_gain_dn) else $error("gain no step"); // R2

  property p_gain_rd;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    ar_hs && (rd_idx == `ISFC_IDX_GAIN) |=>
    S_AXI_RDATA_O == {18'h00000, $past(coarse_code), 2'h0, $past(fine_code)};
  endproperty
  a_gain_rd: assert property (p_gain_rd) else $error("gain readback"); // R3

  property p_extrap;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    extrp_off_r && OSC_GAIN_CHG_I |=> !EXTRAP_ALLOW_O;
  endproperty
  a_extrap: assert property (p_extrap) else $error("extrap allowed"); // R6

  property p_chk_clr;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    oc_state_r == OC_DONE |=> !chk_go_r ##1 oc_state_r == OC_IDLE;
  endproperty
  a_chk_clr: assert property (p_chk_clr) else $error("go not cleared"); // R7

  property p_turn;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    wr_ctrl && wstrb_r[1] && wdata_r[`ISFC_CTRL_TURN_BIT]
    |=> TURN_CNT_CLR_O ##1 !TURN_CNT_CLR_O;
  endproperty
  a_turn: assert property (p_turn) else $error("turn clear pulse"); // R8

  property p_open;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    oc_state_r == OC_SAMPLE |=> open_found_r == $past(|open_sync_r);
  endproperty
  a_open: assert property (p_open) else $error("open flag"); // R9

  property p_dc;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    1'b1 |=> COARSE_ROUTE_O[0].neg_dc == ($past(route_r[1:0]) ==
                                          $past(route_r[3:2]));
  endproperty
  a_dc: assert property (p_dc) else $error("dc tie"); // R11

  property p_rsv;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:16] == 16'h0000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set"); // R14

endmodule

// file: isfc_front_cfg_tb.sv
// self-checking testbench for the front-end configuration registers
`timescale 1ns/1ps
`include "isfc_map.svh"
module isfc_front_cfg_tb
  import isfc_pkg::*;
;
  logic              clk = 0;
  logic              rst = 1;
  logic              awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic              awr, wr_rdy, bv, arr, rv, irq, ext, ten, turn;
  logic [7:0]        awa = 0, ara = 0, open = 0;
  logic [31:0]       wd = 0, rd_d;
  logic [3:0]        ws = 0;
  logic [1:0]        bresp, rresp;
  logic [11:0]       cpk = 12'h800, fpk = 12'h800;
  logic              osc = 0, ofs = 0;
  logic [5:0]        cg, fg;
  isfc_route_t [3:0] route;
  logic [33:0]       rq[$];
  logic [1:0]        bq[$];
  int                num_errors = 0;
  int                tests_run = 0;
  int                tc = 0;

  isfc_front_cfg #(.GAIN_PERIOD_CYC(16), .PEAK_W(12), .N_PINS(8))
    i_isfc_front_cfg (
    .CLK_SYS_I(clk), .RESET_I(rst),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_AWADDR_I(awa),
    .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_rdy), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(ws), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br),
    .S_AXI_BRESP_O(bresp), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_ARADDR_I(ara), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr),
    .S_AXI_RDATA_O(rd_d), .S_AXI_RRESP_O(rresp),
    .COARSE_PEAK_I(cpk), .FINE_PEAK_I(fpk), .OSC_GAIN_CHG_I(osc),
    .OFFSET_CHG_I(ofs), .COIL_OPEN_I(open), .COARSE_GAIN_O(cg),
    .FINE_GAIN_O(fg), .EXTRAP_ALLOW_O(ext), .COIL_TEST_EN_O(ten),
    .TURN_CNT_CLR_O(turn), .COARSE_ROUTE_O(route), .IRQ_O(irq)
  );

  always #2.5 clk = ~clk;

  task automatic summarize;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // axi4-lite write, expected response noted for the watcher
  task automatic wr(input logic [5:0] ix, input logic [15:0] d,
                    input logic [3:0] st, input logic [1:0] er);
    logic a;
    logic w;
    bq.push_back(er);
    awa <= {ix, 2'b00};
    wd <= {16'h0000, d};
    ws <= st;
    awv <= 1;
    wv <= 1;
    br <= 1;
    a = 1;
    w = 1;
    do begin
      @(posedge clk);
      if (a && awr) begin
        a = 0;
        awv <= 0;
      end
      if (w && wr_rdy) begin
        w = 0;
        wv <= 0;
      end
    end while (!(!a && !w && bv));
    br <= 0;
    @(posedge clk);
  endtask

  // axi4-lite read, expected response and data noted for the watcher
  task automatic rd(input logic [5:0] ix, input logic [15:0] d,
                    input logic [1:0] er);
    logic a;
    rq.push_back({er, 16'h0000, d});
    ara <= {ix, 2'b00};
    arv <= 1;
    rr <= 1;
    a = 1;
    do begin
      @(posedge clk);
      if (a && arr) begin
        a = 0;
        arv <= 0;
      end
    end while (!(!a && rv));
    rr <= 0;
    @(posedge clk);
  endtask

  task automatic chk_route(input logic [15:0] v, input logic ch);
    logic [1:0] p;
    logic [1:0] n;
    for (int i = 0; i < 4; i++) begin
      p = v[4*i+2 +: 2];
      n = v[4*i +: 2];
      chk(route[i].neg_dc, p == n);
      chk(route[i].pos_pin, {ch, p});
      if (p != n)
        chk(route[i].neg_pin, {ch, n});
    end
  endtask

  task automatic extrap(input logic off, input logic sel);
    wr(`ISFC_IDX_CTRL, {off, 15'h0000}, 4'h3, 2'h0);
    rd(`ISFC_IDX_CTRL, {off, 15'h0000}, 2'h0);
    if (sel)
      osc <= 1;
    else
      ofs <= 1;
    @(posedge clk);
    osc <= 0;
    ofs <= 0;
    #1 chk(ext, !off);
    @(posedge clk);
    #1 chk(ext, 1'b1);
    @(posedge clk);
  endtask

  task automatic coil(input logic [7:0] o);
    int n;
    open <= o;
    repeat (4) @(posedge clk);
    wr(`ISFC_IDX_CTRL, 16'h2000, 4'h3, 2'h0);
    rd(`ISFC_IDX_CTRL, 16'h2000, 2'h0);
    chk(ten, 1'b1);
    n = 0;
    while (ten && n < 2100) begin
      @(posedge clk);
      n++;
    end
    chk(n < 2100, 1'b1);
    repeat (3) @(posedge clk);
    rd(`ISFC_IDX_CTRL, 16'h0000, 2'h0);
    rd(`ISFC_IDX_STAT, {2'b00, |o, 13'h0000}, 2'h0);
  endtask

  // watcher: pairs each response with the oldest note
  always @(posedge clk) begin
    if (rv && rr) begin
      if (rq.size() == 0)
        chk(0, 1);
      else
        chk({rresp, rd_d}, rq.pop_front());
    end
    if (bv && br) begin
      if (bq.size() == 0)
        chk(0, 1);
      else
        chk(bresp, bq.pop_front());
    end
    if (turn)
      tc++;
  end

  initial begin
    #200000;
    num_errors++;
    summarize();
  end

  initial begin
    int          s;
    logic [15:0] v;
    s = $urandom(32'h87FE);
    repeat (3) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd(`ISFC_IDX_GAIN, 16'h0000, 2'h0);
    rd(`ISFC_IDX_CTRL, 16'h0000, 2'h0);
    rd(`ISFC_IDX_STAT, 16'h0000, 2'h0);
    rd(`ISFC_IDX_ROUTE, 16'hF249, 2'h0);
    chk_route(16'hF249, 1'b0);
    for (int k = 0; k < 8; k++) begin
      v = 16'($urandom);
      wr(`ISFC_IDX_ROUTE, v, 4'h3, 2'h0);
      wr(`ISFC_IDX_CHAN, {15'h0000, k[0]}, 4'h1, 2'h0);
      rd(`ISFC_IDX_ROUTE, v, 2'h0);
      chk_route(v, k[0]);
    end
    wr(`ISFC_IDX_ROUTE, 16'hABCD, 4'h1, 2'h0);
    rd(`ISFC_IDX_ROUTE, {v[15:8], 8'hCD}, 2'h0);
    wr(6'h3F, 16'h1234, 4'h3, 2'h2);
    rd(6'h3F, 16'h0000, 2'h2);
    wr(`ISFC_IDX_CTRL, 16'h5400, 4'h3, 2'h0);
    rd(`ISFC_IDX_CTRL, 16'h0000, 2'h0);
    for (int k = 0; k < 4; k++)
      extrap(k[1], k[0]);
    wr(`ISFC_IDX_CTRL, 16'h0800, 4'h3, 2'h0);
    repeat (3) @(posedge clk);
    chk(tc, 1);
    rd(`ISFC_IDX_CTRL, 16'h0000, 2'h0);
    coil(8'h00);
    coil(8'h01 << ($urandom % 8));
    wr(`ISFC_IDX_GAIN, 16'hFFFF, 4'h3, 2'h0);
    rd(`ISFC_IDX_GAIN, 16'h0000, 2'h0);
    cpk <= 12'h100;
    fpk <= 12'h100;
    repeat (1200) @(posedge clk);
    cpk <= 12'h800;
    fpk <= 12'h800;
    repeat (40) @(posedge clk);
    wr(`ISFC_IDX_GAIN, 16'h0000, 4'h3, 2'h0);
    rd(`ISFC_IDX_GAIN, 16'h3F3F, 2'h0);
    chk(cg, 6'h3F);
    chk(fg, 6'h3F);
    cpk <= 12'hF00;
    repeat (1200) @(posedge clk);
    cpk <= 12'h800;
    repeat (40) @(posedge clk);
    rd(`ISFC_IDX_GAIN, 16'h003F, 2'h0);
    chk(cg, 6'h00);
    fpk <= 12'hF00;
    repeat (1200) @(posedge clk);
    fpk <= 12'h800;
    repeat (40) @(posedge clk);
    rd(`ISFC_IDX_GAIN, 16'h0000, 2'h0);
    chk(fg, 6'h00);
    chk(irq, 1'b0);
    rd(`ISFC_IDX_IRQ_ST, 16'h000F, 2'h0);
    wr(`ISFC_IDX_IRQ_MSK, 16'h0002, 4'h3, 2'h0);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    wr(`ISFC_IDX_IRQ_ST, 16'h000F, 4'h3, 2'h0);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    wr(`ISFC_IDX_CTRL, 16'h0800, 4'h3, 2'h0);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    chk(tc, 2);
    rd(`ISFC_IDX_IRQ_ST, 16'h0004, 2'h0);
    rd(`ISFC_IDX_IRQ_MSK, 16'h0002, 2'h0);
    repeat (5) @(posedge clk);
    chk(rq.size() + bq.size(), 0);
    summarize();
  end
endmodule

// file: isfc_gain_track.sv
// autonomous amplifier gain code tracker for one coil block
`timescale 1ns/1ps
`include "isfc_map.svh"
module isfc_gain_track #(
  parameter int PEAK_W = 12,
  parameter int CODE_W = 6
) (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              tick_i,
  input  wire logic [PEAK_W-1:0] peak_i,
  output logic      [CODE_W-1:0] code_o,
  output logic                   changed_o
);

  logic [CODE_W-1:0] code_r;
  logic [CODE_W-1:0] code_nxt;
  logic              chg_r;
  wire               step_up;
  wire               step_dn;

  // too small: more gain; too large: less gain
  assign step_up = tick_i && (peak_i < `ISFC_PEAK_LO) && (code_r != '1);
  assign step_dn = tick_i && (peak_i > `ISFC_PEAK_HI) && (code_r != '0);
  assign code_nxt = step_up ? code_r + CODE_W'(1) :
                    step_dn ? code_r - CODE_W'(1) : code_r; // R2

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      code_r <= `ISFC_RST_GAIN;
      chg_r  <= 1'b0;
    end else begin
      code_r <= code_nxt;
      chg_r  <= step_up | step_dn;
    end
  end

  assign code_o    = code_r;
  assign changed_o = chg_r;

endmodule

// file: isfc_map.svh
// register map, field positions, reset values and timing counts
`ifndef ISFC_MAP_SVH
`define ISFC_MAP_SVH

`define ISFC_IDX_GAIN       6'h01
`define ISFC_IDX_CTRL       6'h03
`define ISFC_IDX_STAT       6'h04
`define ISFC_IDX_ROUTE      6'h10
`define ISFC_IDX_IRQ_ST     6'h20
`define ISFC_IDX_IRQ_MSK    6'h21
`define ISFC_IDX_CHAN       6'h22

`define ISFC_RST_CTRL       16'h0000
`define ISFC_RST_STAT       16'h0000
`define ISFC_RST_ROUTE      16'hF249
`define ISFC_RST_IRQ        4'h0
`define ISFC_RST_GAIN       6'h00

`define ISFC_CTRL_EXTRP_BIT 15
`define ISFC_CTRL_CHK_BIT   13
`define ISFC_CTRL_TURN_BIT  11
`define ISFC_STAT_OPEN_BIT  13
`define ISFC_CHAN_SEL_BIT   0

`define ISFC_IRQ_CHK_DONE   0
`define ISFC_IRQ_OPEN       1
`define ISFC_IRQ_TURN       2
`define ISFC_IRQ_GAIN       3

`define ISFC_GAIN_BASE      10
`define ISFC_GAIN_RATIO_M   1189
`define ISFC_PEAK_HI        12'hE00
`define ISFC_PEAK_LO        12'h400

`define ISFC_RESP_OKAY      2'h0
`define ISFC_RESP_SLVERR    2'h2

`define ISFC_CLK_NS         5
`define ISFC_OC_SETTLE_NS   10000
`define ISFC_GAIN_PERIOD_NS 1000000

`endif

// file: isfc_pkg.sv
// types shared by the front-end configuration block
package isfc_pkg;

  typedef struct packed {
    logic       neg_dc;
    logic [2:0] neg_pin;
    logic [2:0] pos_pin;
  } isfc_route_t;

  typedef struct packed {
    logic [1:0] rsv_hi;
    logic [5:0] coarse;
    logic [1:0] rsv_lo;
    logic [5:0] fine;
  } isfc_gain_rb_t;

  typedef enum logic [1:0] {
    OC_IDLE,
    OC_SETTLE,
    OC_SAMPLE,
    OC_DONE
  } isfc_oc_state_t;

endpackage
